// ===== dcs_pkg.sv
// Constants and types shared by the chip spreader and its input FIFO.
// Behaviour
// - Data bit 0 maps to symbol +1, data bit 1 maps to symbol -1.
// - Each symbol repeats spreading_factor times in successive chips.
// - Each repeated symbol is multiplied by the current Gold code chip.
// - Gold chip is XOR of two Fibonacci maximum-length generator outputs.
// - Both sequence generators are 25 stages long.
// - First generator uses feedback polynomial x^25 + x^3 + 1.
// - Second generator uses feedback polynomial x^25 + x^3 + x^2 + x + 1.
// - At code start first loads 0x1, second loads the configured vector.
// - The Gold sequence repeats after 33,554,431 chips.
// - Orthogonal code grows from [1]: selector 0 gives CC, 1 gives C,-C.
// - Gold code is primary; orthogonal code further separates networks.
// - BPSK sends positive pulse for chip one, negative for chip zero.
// - Chip index 0 goes first, last_chip_of_symbol goes last.
// - Offset-QPSK even symbols: even chips to I, odd chips to Q.
// - Offset-QPSK odd symbols: even chips to Q, odd chips to I.
// - Offset-QPSK quadrature stream lags in-phase stream by one chip.
package dcs_pkg;

    localparam int unsigned GEN_LEN = 25;
    localparam logic [24:0] FIRST_GEN_INIT = 25'h0000001;
    localparam logic [24:0] FIRST_GEN_TAPS = 25'h0000009;
    localparam logic [24:0] SECOND_GEN_TAPS = 25'h000000f;
    localparam logic [24:0] GOLD_PERIOD = 25'h1ffffff;

    localparam int unsigned IDX_W = 7;
    localparam int unsigned SF_LOG2_W = 3;
    localparam logic [IDX_W-1:0] IDX_RESET = 7'h00;

    localparam int unsigned FIFO_WIDTH = 1;
    localparam int unsigned FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_LAST = 2'b11
    } dcs_state_t;

endpackage

// ===== dcs_spreader.sv
// Input bit FIFO and the chip spreader datapath with BPSK and O-QPSK routing.
`timescale 1ns/1ns

module dcs_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             ready_q;
    logic             empty_q;
    wire              push = i_in_valid && ready_q;
    wire              pop = i_out_ready && !empty_q;

    // Count is updated once per cycle from both handshakes.
    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            ready_q <= 1'b1;
            empty_q <= 1'b1;
        end else begin
            wr_q    <= push ? wr_q + 1'b1 : wr_q;
            rd_q    <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q   <= cnt_d;
            ready_q <= (cnt_d != DEPTH[AW:0]);
            empty_q <= (cnt_d == '0);
        end
    end

    assign o_in_ready  = ready_q;
    assign o_out_valid = !empty_q;
    assign o_out_data  = mem_q[rd_q];

endmodule

module dcs_spreader (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_reset,
    input  wire logic                         i_frame_start,
    input  wire logic                         i_bit_valid,
    input  wire logic                         i_bit,
    output logic                              o_bit_ready,
    input  wire logic [dcs_pkg::SF_LOG2_W-1:0] i_sf_log2,
    input  wire logic [24:0]                  i_gold_iv,
    input  wire logic                         i_orthogonal_tree_code_en,
    input  wire logic [dcs_pkg::IDX_W-1:0]    i_orthogonal_tree_code_sel,
    input  wire logic                         i_oqpsk,
    input  wire logic                         i_chip_ready,
    output logic                              o_chip_valid,
    output logic                              o_chip,
    output logic                              o_inph_upd,
    output logic                              o_inph_chip,
    output logic                              o_quad_upd,
    output logic                              o_quad_chip
);
    // One Fibonacci step: output leaves stage 0, feedback enters stage 24.
    function automatic logic [24:0] gen_step(input logic [24:0] s,
                                             input logic [24:0] taps);
        gen_step = {^(s & taps), s[24:1]};
    endfunction

    // Negation of orthogonal chip k: level i flips the upper half of C(i+1).
    function automatic logic orthogonal_tree_code_neg(input logic [dcs_pkg::IDX_W-1:0] k,
                                      input logic [dcs_pkg::IDX_W-1:0] sel,
                                      input logic [dcs_pkg::IDX_W-1:0] msk);
        orthogonal_tree_code_neg = ^(k & sel & msk);
    endfunction

    dcs_pkg::dcs_state_t state_q;
    dcs_pkg::dcs_state_t state_d;

    logic                      fifo_valid;
    logic                      fifo_bit;
    logic                      fifo_ready_q;
    logic                      fifo_full_n;
    logic [24:0]               gen1_q;
    logic [24:0]               gen2_q;
    logic [dcs_pkg::IDX_W-1:0] idx_q;
    logic                      cur_bit_q;
    logic                      sym_odd_q;
    logic                      q_pend_q;
    logic                      q_pend_chip_q;
    logic                      chip_valid_q;
    logic                      chip_q;
    logic                      inph_upd_q;
    logic                      inph_chip_q;
    logic                      quad_upd_q;
    logic                      quad_chip_q;

    dcs_fifo #(
        .WIDTH (dcs_pkg::FIFO_WIDTH),
        .DEPTH (dcs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_reset     (i_reset),
        .i_in_valid  (i_bit_valid),
        .i_in_data   (i_bit),
        .o_in_ready  (fifo_full_n),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_bit),
        .i_out_ready (fifo_ready_q)
    );

    // Mask of orthogonal tree levels in use and index of the final chip.
    wire [dcs_pkg::IDX_W-1:0] lvl_mask =
        (dcs_pkg::IDX_W)'((8'h01 << i_sf_log2) - 8'h01);
    wire [dcs_pkg::IDX_W-1:0] last_chip_of_symbol = lvl_mask;
    wire at_last = (idx_q == last_chip_of_symbol);

    // The output stage is free when it is empty or being taken this cycle.
    wire out_free = !chip_valid_q || i_chip_ready;
    wire sending = (state_q == dcs_pkg::ST_SEND) ||
                   (state_q == dcs_pkg::ST_LAST);
    wire advance = sending && out_free && !i_frame_start;
    wire flush_pend = !sending && q_pend_q && out_free && !i_frame_start;

    // A new symbol is taken only after the final chip of the previous one.
    wire take_sym = fifo_ready_q && fifo_valid;

    wire [24:0] gen1_nxt = gen_step(gen1_q, dcs_pkg::FIRST_GEN_TAPS);
    wire [24:0] gen2_nxt =
        gen_step(gen2_q, dcs_pkg::SECOND_GEN_TAPS);
    wire gold_chip = gen1_q[0] ^ gen2_q[0];
    wire orth_neg = i_orthogonal_tree_code_en &&
                    orthogonal_tree_code_neg(idx_q, i_orthogonal_tree_code_sel, lvl_mask);
    // Polarity 1 means -1: symbol, Gold and orthogonal signs multiply.
    wire neg_pol = cur_bit_q ^ gold_chip ^ orth_neg;
    wire chip_val = !neg_pol;
    wire to_quad = i_oqpsk && (idx_q[0] ^ sym_odd_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            dcs_pkg::ST_IDLE: begin
                if (take_sym) begin
                    state_d = dcs_pkg::ST_SEND;
                end
            end
            dcs_pkg::ST_SEND: begin
                if (advance && idx_q == last_chip_of_symbol - 1'b1) begin
                    state_d = dcs_pkg::ST_LAST;
                end else if (advance && at_last) begin
                    state_d = dcs_pkg::ST_IDLE;
                end
            end
            dcs_pkg::ST_LAST: begin
                if (advance) begin
                    state_d = dcs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = dcs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_q      <= dcs_pkg::ST_IDLE;
            fifo_ready_q <= 1'b0;
        end else begin
            state_q      <= i_frame_start ? dcs_pkg::ST_IDLE : state_d;
            fifo_ready_q <= !take_sym && state_d == dcs_pkg::ST_IDLE &&
                            !i_frame_start;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cur_bit_q <= 1'b0;
            sym_odd_q <= 1'b0;
            idx_q     <= dcs_pkg::IDX_RESET;
        end else if (i_frame_start) begin
            sym_odd_q <= 1'b0;
            idx_q     <= dcs_pkg::IDX_RESET;
        end else if (take_sym) begin
            cur_bit_q <= fifo_bit;
            idx_q     <= dcs_pkg::IDX_RESET;
        end else if (advance) begin
            idx_q     <= idx_q + 1'b1;
            sym_odd_q <= at_last ? !sym_odd_q : sym_odd_q;
        end
    end

    // Generators run on across symbols and reload only with a new frame.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            gen1_q <= dcs_pkg::FIRST_GEN_INIT;
            gen2_q <= dcs_pkg::FIRST_GEN_INIT;
        end else if (i_frame_start) begin
            gen1_q <= dcs_pkg::FIRST_GEN_INIT;
            gen2_q <= i_gold_iv;
        end else if (advance) begin
            gen1_q <= gen1_nxt;
            gen2_q <= gen2_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || i_frame_start) begin
            chip_valid_q <= 1'b0;
            chip_q       <= 1'b0;
            inph_upd_q   <= 1'b0;
            quad_upd_q   <= 1'b0;
        end else if (advance) begin
            chip_valid_q <= 1'b1;
            chip_q       <= chip_val;
            inph_upd_q   <= !to_quad;
            quad_upd_q   <= q_pend_q;
        end else if (flush_pend) begin
            chip_valid_q <= 1'b1;
            inph_upd_q   <= 1'b0;
            quad_upd_q   <= 1'b1;
        end else if (i_chip_ready) begin
            chip_valid_q <= 1'b0;
            inph_upd_q   <= 1'b0;
            quad_upd_q   <= 1'b0;
        end
    end

    // A quadrature chip waits in a holding stage for one chip period.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || i_frame_start) begin
            q_pend_q      <= 1'b0;
            q_pend_chip_q <= 1'b0;
            inph_chip_q   <= 1'b0;
            quad_chip_q   <= 1'b0;
        end else if (advance) begin
            q_pend_q      <= to_quad;
            q_pend_chip_q <= chip_val;
            inph_chip_q   <= to_quad ? inph_chip_q : chip_val;
            quad_chip_q   <= q_pend_q ? q_pend_chip_q : quad_chip_q;
        end else if (flush_pend) begin
            q_pend_q      <= 1'b0;
            quad_chip_q   <= q_pend_chip_q;
        end
    end

    assign o_bit_ready  = fifo_full_n;
    assign o_chip_valid = chip_valid_q;
    assign o_chip       = chip_q;
    assign o_inph_upd   = inph_upd_q;
    assign o_inph_chip  = inph_chip_q;
    assign o_quad_upd   = quad_upd_q;
    assign o_quad_chip  = quad_chip_q;

    sequence s_adv;
        advance;
    endsequence

    sequence s_frame;
        i_frame_start;
    endsequence

    property p_chip_value;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_adv |=> o_chip == !$past(cur_bit_q ^ gen1_q[0] ^ gen2_q[0] ^
                                   orth_neg);
    endproperty
    a_chip_value: assert property (p_chip_value)
        else $error("chip value is not symbol times code");

    property p_first_chip_plain;
        @(posedge i_clk_sys) disable iff (i_reset)
        advance && (idx_q == 7'h00) |=>
            o_chip == !$past(cur_bit_q ^ gen1_q[0] ^ gen2_q[0]);
    endproperty
    a_first_chip_plain: assert property (p_first_chip_plain)
        else $error("orthogonal root chip is negated");

    property p_index_step;
        @(posedge i_clk_sys) disable iff (i_reset)
        advance && !at_last |=> idx_q == $past(idx_q) + 7'h01 &&
                                cur_bit_q == $past(cur_bit_q);
    endproperty
    a_index_step: assert property (p_index_step)
        else $error("chip index did not step within the symbol");

    property p_gen_shift;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_adv |=> gen1_q[23:0] == $past(gen1_q[24:1]) &&
                  gen2_q[23:0] == $past(gen2_q[24:1]);
    endproperty
    a_gen_shift: assert property (p_gen_shift)
        else $error("sequence generator did not shift once");

    property p_gen1_fb;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_adv |=> gen1_q[24] == $past(gen1_q[0] ^ gen1_q[3]);
    endproperty
    a_gen1_fb: assert property (p_gen1_fb)
        else $error("first generator feedback wrong");

    property p_gen2_fb;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_adv |=> gen2_q[24] ==
            $past(gen2_q[0] ^ gen2_q[1] ^ gen2_q[2] ^ gen2_q[3]);
    endproperty
    a_gen2_fb: assert property (p_gen2_fb)
        else $error("second generator feedback wrong");

    property p_load;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_frame |=> gen1_q == 25'h0000001 && gen2_q == $past(i_gold_iv) &&
                    !o_chip_valid;
    endproperty
    a_load: assert property (p_load)
        else $error("generators not loaded at frame start");

    property p_route_i;
        @(posedge i_clk_sys) disable iff (i_reset)
        advance && i_oqpsk && !(idx_q[0] ^ sym_odd_q) |=> o_inph_upd;
    endproperty
    a_route_i: assert property (p_route_i)
        else $error("chip not routed to in-phase stream");

    property p_quad_lag;
        @(posedge i_clk_sys) disable iff (i_reset)
        (advance || flush_pend) && q_pend_q |=>
            o_quad_upd && o_quad_chip == $past(q_pend_chip_q);
    endproperty
    a_quad_lag: assert property (p_quad_lag)
        else $error("quadrature chip not sent one chip later");

endmodule

// ===== dcs_chip_sink.sv
// Downstream modulator model that paces the chip handshake and logs accepted chips.
`timescale 1ns/1ns

module dcs_chip_sink (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic [1:0] i_pace,
    input  wire logic       i_chip_valid,
    input  wire logic       i_chip,
    input  wire logic       i_inph_upd,
    input  wire logic       i_inph_chip,
    input  wire logic       i_quad_upd,
    input  wire logic       i_quad_chip,
    output logic            o_chip_ready
);
    logic [4:0] log_q[$];
    logic [2:0] cnt_q;

    // Pace 0 takes every cycle, pace 1 stalls two cycles in eight, 2 stops.
    assign o_chip_ready = (i_pace == 2'h0)
                        | ((i_pace == 2'h1) & (cnt_q[2:1] != 2'h3));

    always @(posedge i_clk_sys) begin
        cnt_q <= i_reset ? 3'h0 : cnt_q + 3'h1;
        if (!i_reset && i_chip_valid && o_chip_ready) begin
            log_q.push_back({i_chip, i_inph_upd, i_inph_chip,
                             i_quad_upd, i_quad_chip});
        end
    end
endmodule

// ===== dcs_spreader_test.sv
// Self-checking bench for the chip spreader with a paced chip sink.
`timescale 1ns/1ns

module dcs_spreader_test;
    logic                          clk_sys, reset, frame_start;
    logic                          bit_valid, bit_in, bit_ready;
    logic [dcs_pkg::SF_LOG2_W-1:0] sf_log2;
    logic [24:0]                   gold_iv, g1, g2;
    logic                          orthogonal_tree_code_en, oqpsk, chip_ready, sym_odd;
    logic [dcs_pkg::IDX_W-1:0]     orthogonal_tree_code_sel;
    logic                          chip_valid, chip, inph_upd, inph_chip;
    logic                          quad_upd, quad_chip;
    logic [1:0]                    pace;
    logic                          exp_i[$], exp_q[$];
    int                            bad_count, comparisons;

    dcs_spreader i_dut (
        .i_clk_sys     (clk_sys),
        .i_reset       (reset),
        .i_frame_start (frame_start),
        .i_bit_valid   (bit_valid),
        .i_bit         (bit_in),
        .o_bit_ready   (bit_ready),
        .i_sf_log2     (sf_log2),
        .i_gold_iv     (gold_iv),
        .i_orthogonal_tree_code_en     (orthogonal_tree_code_en),
        .i_orthogonal_tree_code_sel    (orthogonal_tree_code_sel),
        .i_oqpsk       (oqpsk),
        .i_chip_ready  (chip_ready),
        .o_chip_valid  (chip_valid),
        .o_chip        (chip),
        .o_inph_upd    (inph_upd),
        .o_inph_chip   (inph_chip),
        .o_quad_upd    (quad_upd),
        .o_quad_chip   (quad_chip)
    );

    dcs_chip_sink i_sink (
        .i_clk_sys    (clk_sys),
        .i_reset      (reset),
        .i_pace       (pace),
        .i_chip_valid (chip_valid),
        .i_chip       (chip),
        .i_inph_upd   (inph_upd),
        .i_inph_chip  (inph_chip),
        .i_quad_upd   (quad_upd),
        .i_quad_chip  (quad_chip),
        .o_chip_ready (chip_ready)
    );

    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [24:0] iv, input logic [2:0] sfl,
                         input logic oen, input logic [6:0] sel,
                         input logic oq);
        gold_iv = iv;
        sf_log2 = sfl;
        orthogonal_tree_code_en = oen;
        orthogonal_tree_code_sel = sel;
        oqpsk = oq;
        frame_start = 1'b1;
        tick();
        frame_start = 1'b0;
        g1 = 25'h0000001;
        g2 = iv;
        sym_odd = 1'b0;
        exp_i.delete();
        exp_q.delete();
        i_sink.log_q.delete();
        tick();
    endtask

    // Reference chips, generators running on across symbol boundaries.
    task automatic build(input logic [31:0] bits, input int nb);
        int sf;
        logic c;
        logic [6:0] k;
        sf = 1 << sf_log2;
        for (int n = 0; n < nb; n++) begin
            for (int j = 0; j < sf; j++) begin
                k = 7'(j);
                c = ~(bits[n] ^ g1[0] ^ g2[0]
                      ^ (orthogonal_tree_code_en & ^(k & orthogonal_tree_code_sel & 7'(sf - 1))));
                if (!oqpsk || (k[0] ^ sym_odd) == 1'b0) begin
                    exp_i.push_back(c);
                end else begin
                    exp_q.push_back(c);
                end
                g1 = {g1[0] ^ g1[3], g1[24:1]};
                g2 = {^g2[3:0], g2[24:1]};
            end
            sym_odd = ~sym_odd;
        end
    endtask

    task automatic drive(input logic [31:0] bits, input int nb,
                         input int patience, output int acc);
        int idle;
        logic rdy;
        acc = 0;
        idle = 0;
        bit_valid = 1'b1;
        bit_in = bits[0];
        while (acc < nb && idle < patience) begin
            rdy = bit_ready;
            tick();
            idle = rdy ? 0 : idle + 1;
            if (rdy) begin
                acc++;
                bit_in = bits[acc[4:0]];
            end
        end
        bit_valid = 1'b0;
    endtask

    // Waits until the output has been idle for a while, under a bound.
    task automatic settle();
        int q;
        q = 0;
        for (int t = 0; t < 4000 && q < 16; t++) begin
            q = chip_valid ? 0 : q + 1;
            tick();
        end
    endtask

    task automatic judge();
        logic gi[$], gq[$];
        logic [4:0] r;
        foreach (i_sink.log_q[n]) begin
            r = i_sink.log_q[n];
            if (!oqpsk) begin
                gi.push_back(r[4]);
            end else begin
                if (r[3]) gi.push_back(r[2]);
                if (r[1]) gq.push_back(r[0]);
            end
        end
        check(16'(gi.size()), 16'(exp_i.size()));
        check(16'(gq.size()), 16'(exp_q.size()));
        foreach (exp_i[n]) begin
            if (n < gi.size()) check(16'(gi[n]), 16'(exp_i[n]));
        end
        foreach (exp_q[n]) begin
            if (n < gq.size()) check(16'(gq[n]), 16'(exp_q[n]));
        end
    endtask

    task automatic sc_bpsk();
        int acc;
        pace = 2'h0;
        for (int i = 0; i < 2; i++) begin
            frame(25'h0a5c3e1, i ? 3'h0 : 3'h3, 1'b0, 7'h00, 1'b0);
            drive(32'h000000b6, 8, 50, acc);
            build(32'h000000b6, 8);
            settle();
            judge();
        end
    endtask

    task automatic sc_orthogonal_tree_code();
        int acc;
        pace = 2'h1;
        for (int i = 0; i < 2; i++) begin
            frame(25'h1c0ffee, i ? 3'h3 : 3'h1, 1'b1, i ? 7'h65 : 7'h03, 1'b0);
            drive(32'h00000029, 6, 50, acc);
            build(32'h00000029, 6);
            settle();
            judge();
        end
    endtask

    task automatic sc_oqpsk();
        int acc;
        logic [4:0] r;
        pace = 2'h1;
        frame(25'h1234567, 3'h2, 1'b0, 7'h00, 1'b1);
        drive(32'h0000000d, 5, 50, acc);
        build(32'h0000000d, 5);
        settle();
        judge();
        if (i_sink.log_q.size() > 0) begin
            r = i_sink.log_q[0];
            check(16'({r[3], r[1]}), 16'h0002);
        end
    endtask

    task automatic sc_full();
        int acc;
        pace = 2'h2;
        frame(25'h0000f0f, 3'h0, 1'b1, 7'h01, 1'b0);
        drive(32'h5a3c96e1, 24, 12, acc);
        check(16'(acc >= dcs_pkg::FIFO_DEPTH && acc < 24), 16'h0001);
        check(16'(bit_ready), 16'h0000);
        pace = 2'h1;
        build(32'h5a3c96e1, acc);
        settle();
        judge();
    endtask

    task automatic end_of_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        frame_start = 1'b0;
        bit_valid = 1'b0;
        bit_in = 1'b0;
        sf_log2 = '0;
        gold_iv = '0;
        orthogonal_tree_code_en = 1'b0;
        orthogonal_tree_code_sel = '0;
        oqpsk = 1'b0;
        pace = 2'h0;
        bad_count = 0;
        comparisons = 0;
        repeat (8) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        tick();
        check(16'({bit_ready, chip_valid}), 16'h0002);
        sc_bpsk();
        sc_orthogonal_tree_code();
        sc_oqpsk();
        sc_full();
        end_of_test();
    end

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
